//--- rtl/du_pkg.sv
// Shared constants, state types and character-format helpers for the dual serial block.
// Assumes one 100 MHz clock and registers reached by word index over the bus.
package du_pkg;
  // Clocking and a fixed baud rate, sixteen ticks per bit.
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int OVERSAMPLE = 16;
  localparam int TICK_CYCLES = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;
  // Register indices; the byte address is four times the index.
  localparam int ADDR_LSB = 2;
  localparam logic [3:0] CHB_OFS = 4'h8;
  localparam logic [3:0] IDX_MODE = 4'h0;
  localparam logic [3:0] IDX_STAT = 4'h1;
  localparam logic [3:0] IDX_CMD = 4'h2;
  localparam logic [3:0] IDX_DATA = 4'h3;
  localparam logic [3:0] IDX_INPUT_CHANGE_STATUS_ACR = 4'h4;
  localparam logic [3:0] IDX_ISR_IMR = 4'h5;
  localparam logic [3:0] IDX_CTU = 4'h6;
  localparam logic [3:0] IDX_CTL = 4'h7;
  localparam logic [3:0] IDX_IP_OUT_PORT_CONFIG = 4'hD;
  localparam logic [3:0] IDX_OP_SET = 4'hE;
  localparam logic [3:0] IDX_OP_CLR = 4'hF;
  // Mode register one fields.
  localparam int M1_RTS = 7;
  localparam int M1_RXINT = 6;
  localparam int M1_ERRMODE = 5;
  localparam int M1_PTYPE = 2;
  localparam logic [1:0] PMODE_WITH = 2'h0;
  localparam logic [1:0] PMODE_FORCE = 2'h1;
  localparam logic [1:0] PMODE_NONE = 2'h2;
  localparam logic [1:0] PMODE_MULTI = 2'h3;
  // Command nibble codes and status slots carried with each character.
  localparam logic [3:0] CMD_SET_PTR = 4'h1;
  localparam logic [3:0] CMD_RX_RESET = 4'h2;
  localparam logic [3:0] CMD_TX_RESET = 4'h3;
  localparam logic [3:0] CMD_ERR_RESET = 4'h4;
  localparam logic [3:0] CMD_BRK_RESET = 4'h5;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 11;
  // One-hot state codes.
  typedef enum logic [4:0] {
    DU_RX_IDLE = 5'h01, DU_RX_START = 5'h02, DU_RX_BITS = 5'h04, DU_RX_STOP = 5'h08, DU_RX_BRK = 5'h10
  } du_rx_state_type;
  typedef enum logic [1:0] {DU_TX_IDLE = 2'h1, DU_TX_SHIFT = 2'h2} du_tx_state_type;

  // Data bits per character, five to eight.
  function automatic logic [3:0] du_data_bits(input logic [7:0] m);
    return 4'h5 + {2'h0, m[1:0]};
  endfunction

  // True when a parity or address/data bit follows the data bits.
  function automatic logic du_has_extra(input logic [7:0] m);
    return m[4:3] != PMODE_NONE;
  endfunction

  // Value of the extra bit: computed parity, forced level, or address/data flag.
  function automatic logic du_extra_bit(input logic [7:0] m, input logic [7:0] d);
    logic [7:0] msk;
    msk = 8'hFF >> (4'h8 - du_data_bits(m));
    if (m[4:3] == PMODE_WITH) begin
      return (^(d & msk)) ^ m[M1_PTYPE];
    end
    return m[M1_PTYPE];
  endfunction
endpackage

//--- rtl/du_rx_fifo.sv
// Four-entry receive FIFO holding a character and its three status bits.
// Assumes the caller never relies on a push while full or a pop while empty; both are ignored.
`timescale 1ns/100ps
`default_nettype none
module du_rx_fifo (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write side.
  input wire logic clear_in,
  input wire logic push_in,
  input wire logic [du_pkg::FIFO_W-1:0] wdata_in,
  // Read side.
  input wire logic pop_in,
  output logic [du_pkg::FIFO_W-1:0] top_out,
  output logic empty_out,
  output logic full_out
);
  logic [du_pkg::FIFO_DEPTH-1:0][du_pkg::FIFO_W-1:0] mem_q, mem_d;
  logic [2:0] wp_q, wp_d, rp_q, rp_d;
  logic [du_pkg::FIFO_W-1:0] top_q, top_d;

  assign empty_out = wp_q == rp_q;
  assign full_out = (wp_q ^ rp_q) == 3'h4;
  assign top_out = top_q;

  // Pointers carry one wrap bit so full and empty stay distinct; the top entry is re-registered.
  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    if (clear_in) begin
      wp_d = 3'h0;
      rp_d = 3'h0;
    end else begin
      if (push_in && !full_out) begin
        mem_d[wp_q[1:0]] = wdata_in;
        wp_d = wp_q + 3'h1;
      end
      if (pop_in && !empty_out) begin
        rp_d = rp_q + 3'h1;
      end
    end
    top_d = (wp_d == rp_d) ? '0 : mem_d[rp_d[1:0]];
  end

  // State registers.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mem_q <= '0;
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      top_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      top_q <= top_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/du_serial.sv
// One channel's serial transmitter and receiver, framed by mode register one.
// Assumes a sixteen-per-bit tick from the parent and one stop bit on transmit.
`timescale 1ns/100ps
`default_nettype none
module du_serial (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Timing and format.
  input wire logic tick_in,
  input wire logic [7:0] mode_in,
  input wire logic rx_en_in,
  // Line pins.
  input wire logic rxd_in,
  output logic txd_out,
  // Transmit side.
  input wire logic tx_load_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_idle_out,
  // Receive side.
  output logic start_out,
  output logic done_out,
  output logic brk_edge_out,
  output logic [7:0] data_out,
  output logic [2:0] stat_out
);
  du_pkg::du_rx_state_type rx_st_q, rx_st_d;
  du_pkg::du_tx_state_type tx_st_q, tx_st_d;
  logic [3:0] rx_sub_q, rx_sub_d, rx_idx_q, rx_idx_d, tx_sub_q, tx_sub_d, tx_cnt_q, tx_cnt_d, nbits;
  logic [8:0] rx_shf_q, rx_shf_d;
  logic [11:0] tx_shf_q, tx_shf_d;
  logic [7:0] data_q, data_d, rx_data;
  logic [2:0] stat_q, stat_d;
  logic start_q, start_d, done_q, done_d, brk_q, brk_d, extra, has_x, pe;

  assign nbits = du_pkg::du_data_bits(mode_in);
  assign has_x = du_pkg::du_has_extra(mode_in);
  assign rx_data = rx_shf_q[7:0] & (8'hFF >> (4'h8 - nbits));
  assign extra = rx_shf_q[nbits];
  // In multidrop the address/data flag takes the parity error slot.
  assign pe = has_x && ((mode_in[4:3] == du_pkg::PMODE_MULTI) ? extra :
              (extra != du_pkg::du_extra_bit(mode_in, rx_data)));
  assign txd_out = tx_shf_q[0];
  assign tx_idle_out = tx_st_q == du_pkg::DU_TX_IDLE;
  assign start_out = start_q;
  assign done_out = done_q;
  assign brk_edge_out = brk_q;
  assign data_out = data_q;
  assign stat_out = stat_q;

  // Receiver: a start is valid only if the line is still low at mid-bit.
  always_comb begin
    rx_st_d = rx_st_q;
    rx_sub_d = tick_in ? rx_sub_q + 4'h1 : rx_sub_q;
    rx_idx_d = rx_idx_q;
    rx_shf_d = rx_shf_q;
    data_d = data_q;
    stat_d = stat_q;
    start_d = 1'b0;
    done_d = 1'b0;
    brk_d = 1'b0;
    case (rx_st_q)
      du_pkg::DU_RX_IDLE: begin
        rx_sub_d = 4'h0;
        if (rx_en_in && !rxd_in) begin
          rx_st_d = du_pkg::DU_RX_START;
        end
      end
      du_pkg::DU_RX_START: begin
        if (tick_in && rx_sub_q == du_pkg::SUB_MID) begin
          rx_sub_d = 4'h0;
          rx_idx_d = 4'h0;
          rx_shf_d = 9'h000;
          rx_st_d = rxd_in ? du_pkg::DU_RX_IDLE : du_pkg::DU_RX_BITS;
          start_d = !rxd_in;
        end
      end
      du_pkg::DU_RX_BITS: begin
        if (tick_in && rx_sub_q == du_pkg::SUB_LAST) begin
          rx_shf_d[rx_idx_q] = rxd_in;
          rx_idx_d = rx_idx_q + 4'h1;
          if (rx_idx_q == nbits + {3'h0, has_x} - 4'h1) begin
            rx_st_d = du_pkg::DU_RX_STOP;
          end
        end
      end
      du_pkg::DU_RX_STOP: begin
        if (tick_in && rx_sub_q == du_pkg::SUB_LAST) begin
          done_d = 1'b1;
          data_d = rx_data;
          stat_d = {!rxd_in && rx_shf_q == 9'h000, !rxd_in, pe};
          if (!rxd_in && rx_shf_q == 9'h000) begin
            rx_st_d = du_pkg::DU_RX_BRK;
            brk_d = 1'b1;
          end else begin
            rx_st_d = du_pkg::DU_RX_IDLE;
          end
        end
      end
      du_pkg::DU_RX_BRK: begin
        if (rxd_in) begin
          rx_st_d = du_pkg::DU_RX_IDLE;
          brk_d = 1'b1;
        end
      end
      default: rx_st_d = du_pkg::DU_RX_IDLE;
    endcase
  end

  // Transmitter: a whole frame is built at load and shifted out LSB first.
  always_comb begin
    tx_st_d = tx_st_q;
    tx_sub_d = tick_in ? tx_sub_q + 4'h1 : tx_sub_q;
    tx_cnt_d = tx_cnt_q;
    tx_shf_d = tx_shf_q;
    case (tx_st_q)
      du_pkg::DU_TX_IDLE: begin
        tx_sub_d = 4'h0;
        if (tx_load_in) begin
          tx_shf_d = 12'hFFE;
          for (int i = 0; i < 8; i++) begin
            if (i < nbits) begin
              tx_shf_d[i+1] = tx_data_in[i];
            end
          end
          tx_shf_d[4'(nbits + 4'h1)] = has_x ? du_pkg::du_extra_bit(mode_in, tx_data_in) : 1'b1;
          tx_cnt_d = nbits + {3'h0, has_x} + 4'h1;
          tx_st_d = du_pkg::DU_TX_SHIFT;
        end
      end
      du_pkg::DU_TX_SHIFT: begin
        if (tick_in && tx_sub_q == du_pkg::SUB_LAST) begin
          tx_shf_d = {1'b1, tx_shf_q[11:1]};
          tx_cnt_d = tx_cnt_q - 4'h1;
          if (tx_cnt_q == 4'h0) begin
            tx_st_d = du_pkg::DU_TX_IDLE;
          end
        end
      end
      default: tx_st_d = du_pkg::DU_TX_IDLE;
    endcase
  end

  // State registers; the line idles at mark.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_st_q <= du_pkg::DU_RX_IDLE;
      tx_st_q <= du_pkg::DU_TX_IDLE;
      {rx_sub_q, rx_idx_q, tx_sub_q, tx_cnt_q} <= 16'h0000;
      rx_shf_q <= 9'h000;
      tx_shf_q <= 12'hFFF;
      data_q <= 8'h00;
      stat_q <= 3'h0;
      {start_q, done_q, brk_q} <= 3'h0;
    end else begin
      rx_st_q <= rx_st_d;
      tx_st_q <= tx_st_d;
      {rx_sub_q, rx_idx_q, tx_sub_q, tx_cnt_q} <= {rx_sub_d, rx_idx_d, tx_sub_d, tx_cnt_d};
      rx_shf_q <= rx_shf_d;
      tx_shf_q <= tx_shf_d;
      data_q <= data_d;
      stat_q <= stat_d;
      {start_q, done_q, brk_q} <= {start_d, done_d, brk_d};
    end
  end
endmodule
`default_nettype wire

//--- rtl/du_top.sv
// Dual serial channel block: bus registers, mode pointers, error modes, flow control and interrupts.
// Assumes a single AHB-Lite master whose hready is this slave's hreadyout.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - reset or pointer command selects mode one
// - mode one access advances pointer to two
// - request-to-send follows output port bit zero for A, bit one for B
// - full FIFO plus start drops request-to-send
// - port bit kept; reassert when FIFO frees
// - bit six picks ready or full interrupt
// - character mode shows top character status
// - block mode ORs status of top characters
// - parity modes add and check parity
// - parity field eleven selects multidrop mode
// - parity type sets parity or forced level
// - multidrop uses type as address flag polarity
// - length field sets five to eight bits
// - channel B mode registers mirror channel A
// - block errors hold until reset command
module du_top (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // AHB-Lite slave.
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Serial lines.
  input wire logic rxd_a_in,
  input wire logic rxd_b_in,
  output logic txd_a_out,
  output logic txd_b_out,
  // Parallel ports and interrupt.
  input wire logic [6:0] ip_in,
  output logic [7:0] op_n_out,
  output logic irq_n_out
);
  // Bus phase state.
  logic dp_wr_q, dp_wr_d, dp_rd_q, dp_rd_d, dp_ok_q, dp_ok_d, take, wr_fire, rd_fire;
  logic [3:0] dp_idx_q, dp_idx_d;
  logic [7:0] hrdata_q, hrdata_d, rd_val, wdat;
  // Global registers.
  logic [7:0] acr_q, acr_d, imr_q, imr_d, timer_preset_upper_q, timer_preset_upper_d, timer_preset_lower_q, timer_preset_lower_d, out_port_config_q, out_port_config_d, opr_q, opr_d;
  logic [3:0] ip_prev_q, ip_prev_d, ip_delta_q, ip_delta_d;
  logic ip_init_q, irq_n_q, irq_n_d;
  logic [7:0] interrupt_status, op_n_q, op_n_d;
  // Per-channel state, index 0 is channel A.
  logic [1:0][7:0] mode_one_q, mode_one_d, mode_two_q, mode_two_d, thr_q, thr_d, sr, rx_data;
  logic [1:0][2:0] err_acc_q, err_acc_d, rx_stat;
  logic [1:0][du_pkg::FIFO_W-1:0] top;
  logic [1:0] ptr_q, ptr_d, rx_en_q, rx_en_d, tx_en_q, tx_en_d, thr_full_q, thr_full_d;
  logic [1:0] ovr_q, ovr_d, hold_q, hold_d, dbrk_q, dbrk_d;
  logic [1:0] mode_acc, cmd_wr, data_wr, data_rd, fifo_clr, tx_load, tx_idle, rx_start, rx_done;
  logic [1:0] brk_edge, f_empty, f_full, txrdy, rxint, rxd, txd;
  // Baud tick divider.
  logic [9:0] div_q, div_d;
  logic tick;

  // Register index with the channel B offset folded in.
  function automatic logic [3:0] du_cidx(input int ch, input logic [3:0] idx);
    return (ch != 0) ? (idx | du_pkg::CHB_OFS) : idx;
  endfunction

  assign take = hsel_in && htrans_in[1] && hready_in;
  assign wr_fire = dp_wr_q && dp_ok_q;
  assign rd_fire = dp_rd_q && dp_ok_q;
  assign wdat = hwdata_in[7:0];
  // Reads take one wait state so a write just before is always visible.
  assign hreadyout_out = !dp_rd_q;
  assign hresp_out = 1'b0;
  assign hrdata_out = {24'h000000, hrdata_q};
  assign rxd = {rxd_b_in, rxd_a_in};
  assign txd_a_out = txd[0];
  assign txd_b_out = txd[1];
  assign irq_n_out = irq_n_q;
  assign op_n_out = op_n_q;
  assign tick = div_q == 10'(du_pkg::TICK_CYCLES - 1);
  assign div_d = tick ? 10'h000 : div_q + 10'h001;

  // Bus address phase capture; hsize is ignored since only whole words are used.
  always_comb begin
    dp_wr_d = take && hwrite_in;
    dp_rd_d = take && !hwrite_in;
    dp_ok_d = take && haddr_in[31:6] == 26'h0000000 && haddr_in[1:0] == 2'h0;
    dp_idx_d = take ? haddr_in[5:du_pkg::ADDR_LSB] : dp_idx_q;
    hrdata_d = rd_fire ? rd_val : hrdata_q;
  end

  // Per-channel decode, status words and interrupt sources.
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      mode_acc[ch] = (wr_fire || rd_fire) && dp_idx_q == du_cidx(ch, du_pkg::IDX_MODE);
      cmd_wr[ch] = wr_fire && dp_idx_q == du_cidx(ch, du_pkg::IDX_CMD);
      data_wr[ch] = wr_fire && dp_idx_q == du_cidx(ch, du_pkg::IDX_DATA);
      data_rd[ch] = rd_fire && dp_idx_q == du_cidx(ch, du_pkg::IDX_DATA);
      fifo_clr[ch] = cmd_wr[ch] && wdat[7:4] == du_pkg::CMD_RX_RESET;
      tx_load[ch] = thr_full_q[ch] && tx_idle[ch] && tx_en_q[ch];
      txrdy[ch] = tx_en_q[ch] && !thr_full_q[ch];
      rxint[ch] = mode_one_q[ch][du_pkg::M1_RXINT] ? f_full[ch] : !f_empty[ch];
      sr[ch] = {mode_one_q[ch][du_pkg::M1_ERRMODE] ? err_acc_q[ch] : top[ch][10:8],
                ovr_q[ch], txrdy[ch] && tx_idle[ch], txrdy[ch], f_full[ch], !f_empty[ch]};
    end
    interrupt_status = {|(ip_delta_q & acr_q[3:0]), dbrk_q[1], rxint[1], txrdy[1], 1'b0, dbrk_q[0], rxint[0], txrdy[0]};
  end

  // Read data mux; unmapped indices read as zero.
  always_comb begin
    rd_val = 8'h00;
    for (int ch = 0; ch < 2; ch++) begin
      if (dp_idx_q == du_cidx(ch, du_pkg::IDX_MODE)) begin
        rd_val = ptr_q[ch] ? mode_two_q[ch] : mode_one_q[ch];
      end else if (dp_idx_q == du_cidx(ch, du_pkg::IDX_STAT)) begin
        rd_val = sr[ch];
      end else if (dp_idx_q == du_cidx(ch, du_pkg::IDX_DATA)) begin
        rd_val = top[ch][7:0];
      end
    end
    if (dp_idx_q == du_pkg::IDX_INPUT_CHANGE_STATUS_ACR) begin
      rd_val = {ip_delta_q, ip_in[3:0]};
    end else if (dp_idx_q == du_pkg::IDX_ISR_IMR) begin
      rd_val = interrupt_status;
    end else if (dp_idx_q == du_pkg::IDX_IP_OUT_PORT_CONFIG) begin
      rd_val = {1'b0, ip_in};
    end
  end

  // Channel registers; both channels share one body.
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      mode_one_d[ch] = mode_one_q[ch];
      mode_two_d[ch] = mode_two_q[ch];
      ptr_d[ch] = ptr_q[ch];
      rx_en_d[ch] = rx_en_q[ch];
      tx_en_d[ch] = tx_en_q[ch];
      thr_d[ch] = thr_q[ch];
      thr_full_d[ch] = thr_full_q[ch] && !tx_load[ch];
      err_acc_d[ch] = err_acc_q[ch];
      ovr_d[ch] = ovr_q[ch];
      dbrk_d[ch] = dbrk_q[ch];
      if (mode_acc[ch]) begin
        if (wr_fire && ptr_q[ch]) begin
          mode_two_d[ch] = wdat;
        end else if (wr_fire) begin
          mode_one_d[ch] = wdat;
        end
        ptr_d[ch] = 1'b1;
      end
      if (cmd_wr[ch]) begin
        rx_en_d[ch] = (rx_en_q[ch] || wdat[0]) && !wdat[1];
        tx_en_d[ch] = (tx_en_q[ch] || wdat[2]) && !wdat[3];
        case (wdat[7:4])
          du_pkg::CMD_SET_PTR: ptr_d[ch] = 1'b0;
          du_pkg::CMD_RX_RESET: begin
            rx_en_d[ch] = 1'b0;
            err_acc_d[ch] = 3'h0;
            ovr_d[ch] = 1'b0;
          end
          du_pkg::CMD_TX_RESET: begin
            tx_en_d[ch] = 1'b0;
            thr_full_d[ch] = 1'b0;
          end
          du_pkg::CMD_ERR_RESET: begin
            err_acc_d[ch] = 3'h0;
            ovr_d[ch] = 1'b0;
          end
          du_pkg::CMD_BRK_RESET: dbrk_d[ch] = 1'b0;
          default: ;
        endcase
      end
      if (data_wr[ch] && tx_en_q[ch] && !thr_full_q[ch]) begin
        thr_d[ch] = wdat;
        thr_full_d[ch] = 1'b1;
      end
      // Hardware sets win over a clear in the same cycle.
      err_acc_d[ch] = err_acc_d[ch] | top[ch][10:8];
      ovr_d[ch] = ovr_d[ch] || (rx_done[ch] && rx_en_q[ch] && f_full[ch]);
      dbrk_d[ch] = dbrk_d[ch] || brk_edge[ch];
      if (rx_start[ch] && mode_one_q[ch][du_pkg::M1_RTS] && f_full[ch]) begin
        hold_d[ch] = 1'b1;
      end else begin
        hold_d[ch] = hold_q[ch] && f_full[ch];
      end
    end
  end

  // Global registers, input change detect and registered pins.
  always_comb begin
    acr_d = acr_q;
    imr_d = imr_q;
    timer_preset_upper_d = timer_preset_upper_q;
    timer_preset_lower_d = timer_preset_lower_q;
    out_port_config_d = out_port_config_q;
    opr_d = opr_q;
    if (wr_fire && dp_idx_q == du_pkg::IDX_INPUT_CHANGE_STATUS_ACR) begin
      acr_d = wdat;
    end else if (wr_fire && dp_idx_q == du_pkg::IDX_ISR_IMR) begin
      imr_d = wdat;
    end else if (wr_fire && dp_idx_q == du_pkg::IDX_CTU) begin
      timer_preset_upper_d = wdat;
    end else if (wr_fire && dp_idx_q == du_pkg::IDX_CTL) begin
      timer_preset_lower_d = wdat;
    end else if (wr_fire && dp_idx_q == du_pkg::IDX_IP_OUT_PORT_CONFIG) begin
      out_port_config_d = wdat;
    end else if (wr_fire && dp_idx_q == du_pkg::IDX_OP_SET) begin
      opr_d = opr_q | wdat;
    end else if (wr_fire && dp_idx_q == du_pkg::IDX_OP_CLR) begin
      opr_d = opr_q & ~wdat;
    end
    // A read clears the change flags, but a change in that cycle still sets.
    ip_prev_d = ip_in[3:0];
    ip_delta_d = (rd_fire && dp_idx_q == du_pkg::IDX_INPUT_CHANGE_STATUS_ACR) ? 4'h0 : ip_delta_q;
    if (ip_init_q) begin
      ip_delta_d = ip_delta_d | (ip_in[3:0] ^ ip_prev_q);
    end
    irq_n_d = !(|(interrupt_status & imr_q));
    // Pins are the inverse of the effective bit; flow control masks bit 0 and 1 only.
    op_n_d = ~{out_port_config_q[7] ? txrdy[1] : opr_q[7], out_port_config_q[6] ? txrdy[0] : opr_q[6],
               out_port_config_q[5] ? rxint[1] : opr_q[5], out_port_config_q[4] ? rxint[0] : opr_q[4],
               opr_q[3:2], opr_q[1] && !hold_q[1], opr_q[0] && !hold_q[0]};
  end

  // Receive FIFOs and serial engines for both channels.
  for (genvar g = 0; g < 2; g++) begin : g_chan
    du_rx_fifo u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(fifo_clr[g]),
      .push_in(rx_done[g] && rx_en_q[g]),
      .wdata_in({rx_stat[g], rx_data[g]}),
      .pop_in(data_rd[g]),
      .top_out(top[g]),
      .empty_out(f_empty[g]),
      .full_out(f_full[g])
    );
    du_serial u_serial (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(tick),
      .mode_in(mode_one_q[g]),
      .rx_en_in(rx_en_q[g]),
      .rxd_in(rxd[g]),
      .txd_out(txd[g]),
      .tx_load_in(tx_load[g]),
      .tx_data_in(thr_q[g]),
      .tx_idle_out(tx_idle[g]),
      .start_out(rx_start[g]),
      .done_out(rx_done[g]),
      .brk_edge_out(brk_edge[g]),
      .data_out(rx_data[g]),
      .stat_out(rx_stat[g])
    );
  end

  // All state registers; pins come out of flip-flops.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {dp_wr_q, dp_rd_q, dp_ok_q} <= 3'h0;
      dp_idx_q <= 4'h0;
      hrdata_q <= 8'h00;
      {acr_q, imr_q, timer_preset_upper_q, timer_preset_lower_q, out_port_config_q, opr_q} <= {6{du_pkg::REG_RST}};
      {ip_prev_q, ip_delta_q} <= 8'h00;
      ip_init_q <= 1'b0;
      irq_n_q <= 1'b1;
      op_n_q <= 8'hFF;
      {mode_one_q, mode_two_q, thr_q} <= {6{du_pkg::REG_RST}};
      err_acc_q <= 6'h00;
      {ptr_q, rx_en_q, tx_en_q, thr_full_q, ovr_q, hold_q, dbrk_q} <= 14'h0000;
      div_q <= 10'h000;
    end else begin
      {dp_wr_q, dp_rd_q, dp_ok_q} <= {dp_wr_d, dp_rd_d, dp_ok_d};
      dp_idx_q <= dp_idx_d;
      hrdata_q <= hrdata_d;
      {acr_q, imr_q, timer_preset_upper_q, timer_preset_lower_q, out_port_config_q, opr_q} <= {acr_d, imr_d, timer_preset_upper_d, timer_preset_lower_d, out_port_config_d, opr_d};
      {ip_prev_q, ip_delta_q} <= {ip_prev_d, ip_delta_d};
      ip_init_q <= 1'b1;
      irq_n_q <= irq_n_d;
      op_n_q <= op_n_d;
      {mode_one_q, mode_two_q, thr_q} <= {mode_one_d, mode_two_d, thr_d};
      err_acc_q <= err_acc_d;
      {ptr_q, rx_en_q, tx_en_q, thr_full_q, ovr_q, hold_q, dbrk_q} <=
        {ptr_d, rx_en_d, tx_en_d, thr_full_d, ovr_d, hold_d, dbrk_d};
      div_q <= div_d;
    end
  end
endmodule
`default_nettype wire

//--- verification/du_top_properties.sv
// Bus, port pin and interrupt pin checks for the dual serial block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module du_top_properties (
  // Clock, reset and bus.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Pins.
  input wire logic txd_a_out,
  input wire logic [7:0] op_n_out,
  input wire logic irq_n_out
);
  logic rd_q, wr_q, rd_d, wr_d;
  logic [3:0] idx_q, idx_d;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Data phase tracking; forced off in reset so no stale phase survives it.
  always_comb begin
    rd_d = rst_n_in && hsel_in && htrans_in[1] && hready_in && !hwrite_in;
    wr_d = rst_n_in && hsel_in && htrans_in[1] && hready_in && hwrite_in;
    idx_d = haddr_in[5:2];
  end
  // Registered copy of the phase.
  always_ff @(posedge clk_in) begin
    rd_q <= rd_d;
    wr_q <= wr_d;
    idx_q <= idx_d;
  end
  a_read_wait: assert property (rd_q |-> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_q |-> hreadyout_out)
    else $error("write stalled");
  a_resp_okay: assert property (!hresp_out)
    else $error("response not okay");
  a_rdata_hold: assert property ($changed(hrdata_out) |-> $past(rd_q))
    else $error("read data moved");
  a_rdata_upper: assert property (hrdata_out[31:8] == 24'h000000)
    else $error("upper read data set");
  a_reset_pins: assert property (disable iff (1'b0) !rst_n_in |=> op_n_out == 8'hFF && irq_n_out && txd_a_out)
    else $error("pins wrong after reset");
  a_port_set: assert property (wr_q && idx_q == 4'hE && hwdata_in[2] |-> ##[1:3] !op_n_out[2])
    else $error("port set missed");
  a_port_clear: assert property (wr_q && idx_q == 4'hF && hwdata_in[2] |-> ##[1:3] op_n_out[2])
    else $error("port clear missed");
  a_mask_quiet: assert property (wr_q && idx_q == 4'h5 && hwdata_in[7:0] == 8'h00 |-> ##[1:3] irq_n_out)
    else $error("masked interrupt active");
endmodule
`default_nettype wire

//--- verification/du_remote_tx.sv
// Remote serial sender on channel A: idles at mark, frames start only on clear-to-send.
// Assumes clear-to-send is the block's request-to-send pin, active low.
`timescale 1ns/100ps
`default_nettype none
module du_remote_tx #(parameter int BIT_CYC = 10416) (
  input wire logic clk_in,
  input wire logic cts_n_in,
  input wire logic send_in,
  input wire logic [7:0] data_in,
  output logic rxd_out
);
  int cnt = 0;
  logic [9:0] sh = 10'h3FF;
  // A frame begins only while idle and cleared; one begun while the receive FIFO is full still completes and can overrun it.
  always @(posedge clk_in) begin
    if (cnt == 0 && send_in && !cts_n_in) begin
      sh <= {1'b1, data_in, 1'b0};
      cnt <= 10 * BIT_CYC;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if ((cnt - 1) % BIT_CYC == 0) sh <= {1'b1, sh[9:1]};
    end
  end
  assign rxd_out = sh[0];
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Bench: bus tasks reach the registers; the remote sender idles on channel A.
// Assumes the checker is bound below and a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, rxd_b_in = 1'b1;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, dat_s;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [6:0] ip_in = 7'h7F;
  logic hrdy_s, hreadyout_out, hresp_out, txd_a_out, txd_b_out, irq_n_out, rxd_a_in;
  logic [7:0] op_n_out, q;
  logic [3:0] c;
  wire logic hready_in = hreadyout_out;
  int err_count = 0, checked = 0;
  du_top du_top_inst (.*);
  du_remote_tx du_remote_tx_inst (.clk_in(clk_in), .cts_n_in(op_n_out[0]), .send_in(1'b0), .data_in(8'h55),
    .rxd_out(rxd_a_in));
  // Half-period clock toggle.
  always #5 clk_in = ~clk_in;
  // Bus answers are captured mid-cycle, settled before the rising edge that takes them.
  always @(negedge clk_in) begin
    hrdy_s <= hreadyout_out;
    dat_s <= hrdata_out;
  end
  // One single-word transfer: address phase, then data phase; read byte lands in q.
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= {26'h0, i, 2'h0};
    @(posedge clk_in);
    while (hrdy_s !== 1'b1) @(posedge clk_in);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= {24'h0, d};
    @(posedge clk_in);
    while (hrdy_s !== 1'b1) @(posedge clk_in);
    q = dat_s[7:0];
  endtask
  // Compare and count.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read one register and compare its low byte.
  task automatic rd(input logic [3:0] i, input logic [7:0] e, input string n);
    bus(1'b0, i, 8'h00);
    chk(n, e, q);
  endtask
  // Write one register, then let the registered pins settle.
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
    repeat (3) @(posedge clk_in);
  endtask
  // Verdict and end of run.
  task automatic results;
    $display("%0d checked, %0d bad", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    #20000;
    err_count++;
    results;
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    for (int k = 0; k < 2; k++) begin
      c = k ? 4'h8 : 4'h0;
      wr(c, 8'h93);
      wr(c, 8'h17);
      wr(c | 4'h2, 8'h10);
      rd(c, 8'h93, "mode one");
      rd(c, 8'h17, "mode two");
    end
    $display("pointer test done");
    wr(4'hE, 8'h1D);
    chk("port set", 8'hE2, op_n_out);
    wr(4'hD, 8'h10);
    chk("rx int pin", 8'hF2, op_n_out);
    wr(4'hF, 8'h05);
    chk("port clear", 8'hF7, op_n_out);
    $display("port test done");
    wr(4'h2, 8'h04);
    rd(4'h5, 8'h01, "int status");
    rd(4'h1, 8'h0C, "status A");
    chk("tx lines idle", 8'h03, {6'h0, txd_b_out, txd_a_out});
    wr(4'h5, 8'h01);
    chk("irq on", 8'h00, {7'h0, irq_n_out});
    wr(4'h5, 8'h00);
    chk("irq off", 8'h01, {7'h0, irq_n_out});
    $display("interrupt test done");
    wr(4'h4, 8'h01);
    ip_in <= 7'h7E;
    repeat (3) @(posedge clk_in);
    rd(4'h5, 8'h81, "port change");
    rd(4'h4, 8'h1E, "change latched");
    rd(4'h4, 8'h0E, "change cleared");
    rd(4'hD, 8'h7E, "input pins");
    rd(4'hC, 8'h00, "reserved");
    $display("input test done");
    results;
  end
endmodule
bind du_top du_top_properties du_top_properties_inst (.*);
`default_nettype wire
